// ---- src/servo_od_defines.svh ----
// object dictionary constants: indices, subindices, reset values, limits
// assumes inclusion by servo_od_pkg and the core module only
`ifndef SERVO_OD_DEFINES_SVH
`define SERVO_OD_DEFINES_SVH

`define IDX_DEVICE_PROFILE   16'h1000
`define IDX_FAULT_SUMMARY    16'h1001
`define IDX_FAULT_HISTORY    16'h1003
`define IDX_PARAM_STORE      16'h1010
`define IDX_IDENTITY         16'h1018
`define IDX_RX_MAP_FIRST     16'h1600
`define DEVICE_PROFILE_RESET 32'h00020192
`define SUMMARY_MASK         8'hbf
`define HIST_DEPTH           8
`define HIST_MAX             4'h8
`define STORE_SUB_HIGHEST    8'h03
`define STORE_SUB_CMD        8'h03
`define STORE_SIGNATURE      32'h65766173
`define IDENT_ENTRIES        8'h04
`define MAP_OBJECTS          8
`define MAP_ENTRIES          8
`define MAP_MAX_ENTRIES      4'h8
`define MAP_MAX_BITS         12'h100
`define PARAM_COUNT          7
`define RX1_COUNT            4'h2
`define RX1_ENTRY1           32'h60400010
`define RX1_ENTRY2           32'h60ff0020
`define RST_HOME_OFFSET      32'h00000000
`define RST_GEAR_NUM         32'h00000001
`define RST_GEAR_DEN         32'h00000001
`define RST_HOMING_METHOD    32'h00000001
`define RST_SWITCH_SPEED     32'h00001388
`define RST_ZERO_SPEED       32'h00000064
`define RST_HOMING_ACCEL     32'h000f4240

`endif

// ---- src/servo_od_pkg.sv ----
// types shared by the object dictionary core
// assumes servo_od_defines.svh on the include path
`include "servo_od_defines.svh"
package servo_od_pkg;
    typedef logic [31:0] word_t;
    typedef struct packed {
        logic                                          ack;
        logic                                          abort;
        logic                                          store_done;
        word_t                                         rdata;
        logic [7:0]                                    summary;
        logic [3:0]                                    hist_cnt;
        logic [`HIST_DEPTH-1:0][31:0]                  hist;
        logic [`PARAM_COUNT-1:0][31:0]                 params;
        logic [`MAP_OBJECTS-1:0][3:0]                  map_cnt;
        logic [`MAP_OBJECTS-1:0][`MAP_ENTRIES-1:0][31:0] map;
    } state_t;
endpackage

// ---- src/servo_object_dictionary_core.sv ----
// general objects and process-data mapping objects of a servo drive dictionary
// assumes a master-side engine that issues one indexed access per od_req pulse
// Operation
// - the device type word reads as profile number in the low half and servo type above.
// - the 8-bit fault summary mirrors fault flags with bit 6 held at zero.
// - up to eight alarms are kept and subindex 0 counts them, capped at eight.
// - each history entry holds the alarm number low and its emergency code high.
// - writing the save signature to store subindex 3 copies object values into parameters.
// - the store covers home offset, gear terms, homing method, both speeds and acceleration.
// - reading store subindex 3 gives autonomous save in bit 0, command save in bit 1, zeros above.
// - a store runs only while the servo is off and the master must not ask otherwise.
// - with autonomous saving the device updates parameters without the signature while the servo is off.
// - the identity block has four read-only words and the serial number reads zero.
// - the revision word joins a major part for behaviour changes and a minor part.
// - a mapping entry holds length in bits 0-7, subindex in 8-15 and index in 16-31.
// - mapping changes are accepted only in the pre-operational network state.
// - there are four receive and four transmit mapping objects, each configured alone.
// - a mapping holds at most eight entries totalling at most thirty-two bytes.
`include "servo_od_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module servo_object_dictionary_core
    import servo_od_pkg::*;
#(
    parameter logic [31:0] VENDOR_CODE  = 32'h00000001,  // arbitrary value
    parameter logic [31:0] PRODUCT_CODE = 32'h00000002,  // arbitrary value
    parameter logic [15:0] REV_MAJOR    = 16'h0001,
    parameter logic [15:0] REV_MINOR    = 16'h0000,
    parameter logic        AUTO_SAVE    = 1'b0,
    parameter logic        CMD_SAVE     = 1'b1
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        od_req,
    input  wire logic        od_write,
    input  wire logic [15:0] od_index,
    input  wire logic [7:0]  od_subindex,
    input  wire logic [31:0] od_wdata,
    output logic             od_ack,
    output logic             od_abort,
    output logic [31:0]      od_rdata,
    input  wire logic        servo_on,
    input  wire logic        net_preop,
    input  wire logic [7:0]  fault_flags,
    input  wire logic        alarm_event,
    input  wire logic [15:0] alarm_number,
    input  wire logic [15:0] alarm_emcy,
    input  wire logic [31:0] obj_home_offset,
    input  wire logic [31:0] obj_gear_num,
    input  wire logic [31:0] obj_gear_den,
    input  wire logic [31:0] obj_homing_method,
    input  wire logic [31:0] obj_switch_speed,
    input  wire logic [31:0] obj_zero_speed,
    input  wire logic [31:0] obj_homing_accel,
    output logic [31:0]      home_offset_param,
    output logic [31:0]      gear_numerator_param,
    output logic [31:0]      gear_denominator_param,
    output logic [31:0]      homing_method_param,
    output logic [31:0]      switch_search_speed_param,
    output logic [31:0]      zero_search_speed_param,
    output logic [31:0]      homing_accel_param,
    output logic             store_done,
    output logic [7:0]       fault_summary
);

    ////////////////////////////////////////////////////////////////////////////
    state_t                          s_q;
    state_t                          s_d;
    logic [`PARAM_COUNT-1:0][31:0]   obj_val;
    logic [7:0]                      sub_m1;
    logic                            map_hit;
    logic [2:0]                      map_sel;
    logic                            sub_entry;
    logic                            store_ok;

    // order matches params slots 0..6
    assign obj_val = {obj_homing_accel, obj_zero_speed, obj_switch_speed,
                      obj_homing_method, obj_gear_den, obj_gear_num, obj_home_offset};
    assign sub_m1    = od_subindex - 8'h01;
    assign sub_entry = (od_subindex != 8'h00) && (od_subindex <= 8'h08);
    // receive objects at 16xx, transmit at 1axx, four of each
    assign map_hit = (od_index[15:12] == 4'h1) && od_index[9] && (od_index[8:2] == 7'h00)
                     && (od_index[11] ^ od_index[10]);
    assign map_sel = {od_index[11], od_index[1:0]};
    // refusal while energized keeps a half-written parameter set off the drive
    assign store_ok = CMD_SAVE && !servo_on && (od_wdata == `STORE_SIGNATURE);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [11:0] size_bits;
        size_bits = 12'h000;
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.abort = 1'b0;
        s_d.store_done = 1'b0;
        s_d.summary = fault_flags & `SUMMARY_MASK;
        if (alarm_event)
        begin
            for (int k = `HIST_DEPTH - 1; k > 0; k--)
            begin
                s_d.hist[k] = s_q.hist[k-1];
            end
            s_d.hist[0] = {alarm_emcy, alarm_number};
            if (s_q.hist_cnt < `HIST_MAX)
            begin
                s_d.hist_cnt = s_q.hist_cnt + 4'h1;
            end
        end
        if (AUTO_SAVE && !servo_on)
        begin
            s_d.params = obj_val;
        end
        for (int k = 0; k < `MAP_ENTRIES; k++)
        begin
            if (k < int'(od_wdata[3:0]))
            begin
                size_bits = size_bits + {4'h0, s_q.map[map_sel][k][7:0]};
            end
        end
        if (od_req)
        begin
            s_d.ack = 1'b1;
            s_d.rdata = 32'h00000000;
            if (map_hit)
            begin
                if (od_write)
                begin
                    if (!net_preop)
                    begin
                        s_d.abort = 1'b1;
                    end
                    else if (od_subindex == 8'h00)
                    begin
                        if ((od_wdata > 32'(`MAP_MAX_ENTRIES)) || (size_bits > `MAP_MAX_BITS))
                        begin
                            s_d.abort = 1'b1;
                        end
                        else
                        begin
                            s_d.map_cnt[map_sel] = od_wdata[3:0];
                        end
                    end
                    else if (sub_entry && (s_q.map_cnt[map_sel] == 4'h0))
                    begin
                        s_d.map[map_sel][sub_m1[2:0]] = od_wdata;
                    end
                    else
                    begin
                        // entries change only while the count is zero
                        s_d.abort = 1'b1;
                    end
                end
                else if (od_subindex == 8'h00)
                begin
                    s_d.rdata = {28'h0000000, s_q.map_cnt[map_sel]};
                end
                else if (sub_entry)
                begin
                    s_d.rdata = s_q.map[map_sel][sub_m1[2:0]];
                end
                else
                begin
                    s_d.abort = 1'b1;
                end
            end
            else if (od_write)
            begin
                if ((od_index == `IDX_PARAM_STORE) && (od_subindex == `STORE_SUB_CMD)
                    && store_ok)
                begin
                    s_d.params = obj_val;
                    s_d.store_done = 1'b1;
                end
                else
                begin
                    s_d.abort = 1'b1;
                end
            end
            else
            begin
                case (od_index)
                    `IDX_DEVICE_PROFILE:
                    begin
                        s_d.rdata = `DEVICE_PROFILE_RESET;
                        s_d.abort = (od_subindex != 8'h00);
                    end
                    `IDX_FAULT_SUMMARY:
                    begin
                        s_d.rdata = {24'h000000, s_q.summary};
                        s_d.abort = (od_subindex != 8'h00);
                    end
                    `IDX_FAULT_HISTORY:
                    begin
                        if (od_subindex == 8'h00)
                        begin
                            s_d.rdata = {28'h0000000, s_q.hist_cnt};
                        end
                        else if (sub_entry)
                        begin
                            s_d.rdata = s_q.hist[sub_m1[2:0]];
                        end
                        else
                        begin
                            s_d.abort = 1'b1;
                        end
                    end
                    `IDX_PARAM_STORE:
                    begin
                        case (od_subindex)
                            8'h00: s_d.rdata = {24'h000000, `STORE_SUB_HIGHEST};
                            8'h01: s_d.rdata = 32'h00000000;
                            8'h02: s_d.rdata = 32'h00000000;
                            8'h03: s_d.rdata = {30'h00000000, CMD_SAVE, AUTO_SAVE};
                            default: s_d.abort = 1'b1;
                        endcase
                    end
                    `IDX_IDENTITY:
                    begin
                        case (od_subindex)
                            8'h00: s_d.rdata = {24'h000000, `IDENT_ENTRIES};
                            8'h01: s_d.rdata = VENDOR_CODE;
                            8'h02: s_d.rdata = PRODUCT_CODE;
                            8'h03: s_d.rdata = {REV_MAJOR, REV_MINOR};
                            8'h04: s_d.rdata = 32'h00000000;
                            default: s_d.abort = 1'b1;
                        endcase
                    end
                    default: s_d.abort = 1'b1;
                endcase
            end
        end
        if (sys_rst)
        begin
            s_d = '0;
            s_d.params = {`RST_HOMING_ACCEL, `RST_ZERO_SPEED, `RST_SWITCH_SPEED,
                          `RST_HOMING_METHOD, `RST_GEAR_DEN, `RST_GEAR_NUM,
                          `RST_HOME_OFFSET};
            s_d.map_cnt[0] = `RX1_COUNT;
            s_d.map[0][0] = `RX1_ENTRY1;
            s_d.map[0][1] = `RX1_ENTRY2;
        end
    end

    always_ff @(posedge clk)
    begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign od_ack                    = s_q.ack;
    assign od_abort                  = s_q.abort;
    assign od_rdata                  = s_q.rdata;
    assign store_done                = s_q.store_done;
    assign fault_summary             = s_q.summary;
    assign home_offset_param         = s_q.params[0];
    assign gear_numerator_param      = s_q.params[1];
    assign gear_denominator_param    = s_q.params[2];
    assign homing_method_param       = s_q.params[3];
    assign switch_search_speed_param = s_q.params[4];
    assign zero_search_speed_param   = s_q.params[5];
    assign homing_accel_param        = s_q.params[6];

    ////////////////////////////////////////////////////////////////////////////
    a_profile_read_value: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && !od_write && (od_index == 16'h1000) && (od_subindex == 8'h00)
        |=> od_ack && !od_abort && (od_rdata == 32'h00020192))
        else $error("device type word wrong");

    // the summary is cleared by reset, so the cycle after reset is not compared with the flags
    a_summary_bit_six: assert property (@(posedge clk) disable iff (sys_rst)
        !fault_summary[6] && ($past(sys_rst) || ($past(fault_flags[0]) == fault_summary[0])))
        else $error("fault summary bit wrong");

    a_history_cap: assert property (@(posedge clk) disable iff (sys_rst)
        alarm_event && (s_q.hist_cnt == 4'h8) |=> (s_q.hist_cnt == 4'h8))
        else $error("history count exceeded eight");

    a_history_push: assert property (@(posedge clk) disable iff (sys_rst)
        alarm_event |=> (s_q.hist[0] == {$past(alarm_emcy), $past(alarm_number)}))
        else $error("history entry not captured");

    a_store_signature: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && od_write && (od_index == 16'h1010) && (od_subindex == 8'h03)
        && (od_wdata == 32'h65766173) && !servo_on
        |=> store_done && (home_offset_param == $past(obj_home_offset)))
        else $error("store did not copy objects");

    a_store_servo_off: assert property (@(posedge clk) disable iff (sys_rst)
        store_done |-> !$past(servo_on))
        else $error("store ran while servo on");

    a_store_caps_read: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && !od_write && (od_index == 16'h1010) && (od_subindex == 8'h03)
        |=> (od_rdata[31:2] == 30'h0) && (od_rdata[1:0] == {CMD_SAVE, AUTO_SAVE}))
        else $error("store capability word wrong");

    a_serial_zero: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && !od_write && (od_index == 16'h1018) && (od_subindex == 8'h04)
        |=> !od_abort && (od_rdata == 32'h0))
        else $error("serial number not zero");

    a_map_state_lock: assert property (@(posedge clk) disable iff (sys_rst)
        !net_preop |=> $stable(s_q.map_cnt) && $stable(s_q.map))
        else $error("mapping changed outside pre-operational");

    a_map_count_limit: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && od_write && map_hit && (od_subindex == 8'h00) && (od_wdata > 32'h8)
        |=> od_abort && (s_q.map_cnt == $past(s_q.map_cnt)))
        else $error("mapping count above eight accepted");

    a_auto_save_follow: assert property (@(posedge clk) disable iff (sys_rst)
        AUTO_SAVE && !servo_on |=> (homing_accel_param == $past(obj_homing_accel)))
        else $error("autonomous save did not follow objects");

    a_ro_write_refused: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && od_write && !map_hit && (od_index != 16'h1010)
        |=> od_abort && !store_done)
        else $error("write to read-only object accepted");

    a_history_count_read: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && !od_write && (od_index == 16'h1003) && (od_subindex == 8'h00)
        |=> !od_abort && (od_rdata == {28'h0, $past(s_q.hist_cnt)}))
        else $error("history count read wrong");

    a_map_entry_read: assert property (@(posedge clk) disable iff (sys_rst)
        od_req && !od_write && map_hit && (od_subindex == 8'h01)
        |=> !od_abort && (od_rdata == $past(s_q.map[map_sel][0])))
        else $error("mapping entry read wrong");

    a_rx_map_default: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> (s_q.map_cnt[0] == 4'h2) && (s_q.map[0][1] == 32'h60ff0020))
        else $error("first receive mapping default wrong");

endmodule

`default_nettype wire

// ---- verif/od_master_model.sv ----
// fieldbus master model: issues indexed accesses to the object dictionary core
// assumes the core answers with od_ack one cycle after the request edge
`timescale 1ns/1ps
`default_nettype none

module od_master_model (
    input  wire logic        clk,
    output logic             od_req,
    output logic             od_write,
    output logic [15:0]      od_index,
    output logic [7:0]       od_subindex,
    output logic [31:0]      od_wdata,
    input  wire logic        od_ack,
    input  wire logic        od_abort,
    input  wire logic [31:0] od_rdata
);
    initial
    begin
        od_req = 1'b0;
        {od_write, od_index, od_subindex, od_wdata} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ab,
                          output logic ok);
        @(posedge clk);
        od_req      <= 1'b1;
        {od_write, od_index, od_subindex, od_wdata} <= {wr, idx, sub, wd};
        @(posedge clk);
        // released lines carry the inverse so a stale value is never taken as data
        od_req      <= 1'b0;
        {od_write, od_index, od_subindex, od_wdata} <= ~{wr, idx, sub, wd};
        ok = 1'b0;
        for (int n = 0; n < 4; n++)
        begin
            #1;
            if (od_ack === 1'b1)
            begin
                ok = 1'b1;
                break;
            end
            @(posedge clk);
        end
        rd = od_rdata;
        ab = od_abort;
    endtask

    // count first to zero, then entries, then the count: entries are refused while counted
    task automatic remap(input logic [15:0] idx, input logic [31:0] ent, input logic [3:0] cnt,
                         output logic ok, output logic ab);
        logic [31:0] rd;
        logic        a;
        logic        k;
        access(1'b1, idx, 8'h00, 32'h0, rd, a, ok);
        ok = ok & ~a;
        for (int i = 1; i <= int'(cnt); i++)
        begin
            access(1'b1, idx, i[7:0], ent, rd, a, k);
            ok = ok & k & ~a;
        end
        access(1'b1, idx, 8'h00, {28'h0, cnt}, rd, ab, k);
        ok = ok & k;
    endtask
endmodule

`default_nettype wire

// ---- verif/servo_object_dictionary_core_tb_top.sv ----
// testbench for the object dictionary core: scenario tasks over the master model
// assumes the core and od_master_model are compiled before this file
`timescale 1ns/1ps
`default_nettype none

module servo_object_dictionary_core_tb_top
    import servo_od_pkg::*;
;
    localparam logic [31:0] VENDOR    = 32'h00000abc; // arbitrary value
    localparam logic [31:0] PRODUCT   = 32'h00000def; // arbitrary value
    localparam logic [31:0] SIGNATURE = 32'h65766173;
    logic        clk, sys_rst, servo_on, net_preop, alarm_event, store_done;
    logic        od_req, od_write, od_ack, od_abort;
    logic [7:0]  fault_flags, fault_summary, od_subindex;
    logic [15:0] alarm_number, alarm_emcy, od_index;
    logic [31:0] od_wdata, od_rdata;
    logic [31:0] obj [7];
    logic [31:0] par [7];
    logic [31:0] par_auto [7];
    int          fails;
    int          comparisons;

    servo_object_dictionary_core #(.VENDOR_CODE(VENDOR), .PRODUCT_CODE(PRODUCT),
        .REV_MAJOR(16'h0002), .REV_MINOR(16'h0005)) DUT (
        .clk(clk), .sys_rst(sys_rst), .od_req(od_req), .od_write(od_write),
        .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
        .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata), .servo_on(servo_on),
        .net_preop(net_preop), .fault_flags(fault_flags), .alarm_event(alarm_event),
        .alarm_number(alarm_number), .alarm_emcy(alarm_emcy),
        .obj_home_offset(obj[0]), .obj_gear_num(obj[1]), .obj_gear_den(obj[2]),
        .obj_homing_method(obj[3]), .obj_switch_speed(obj[4]), .obj_zero_speed(obj[5]),
        .obj_homing_accel(obj[6]), .home_offset_param(par[0]),
        .gear_numerator_param(par[1]), .gear_denominator_param(par[2]),
        .homing_method_param(par[3]), .switch_search_speed_param(par[4]),
        .zero_search_speed_param(par[5]), .homing_accel_param(par[6]),
        .store_done(store_done), .fault_summary(fault_summary));

    // second core with autonomous saving; only its parameters are judged
    servo_object_dictionary_core #(.AUTO_SAVE(1'b1)) DUT_AUTO (
        .clk(clk), .sys_rst(sys_rst), .od_req(od_req), .od_write(od_write),
        .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
        .od_ack(), .od_abort(), .od_rdata(), .servo_on(servo_on),
        .net_preop(net_preop), .fault_flags(fault_flags), .alarm_event(alarm_event),
        .alarm_number(alarm_number), .alarm_emcy(alarm_emcy),
        .obj_home_offset(obj[0]), .obj_gear_num(obj[1]), .obj_gear_den(obj[2]),
        .obj_homing_method(obj[3]), .obj_switch_speed(obj[4]), .obj_zero_speed(obj[5]),
        .obj_homing_accel(obj[6]), .home_offset_param(par_auto[0]),
        .gear_numerator_param(par_auto[1]), .gear_denominator_param(par_auto[2]),
        .homing_method_param(par_auto[3]), .switch_search_speed_param(par_auto[4]),
        .zero_search_speed_param(par_auto[5]), .homing_accel_param(par_auto[6]),
        .store_done(), .fault_summary());

    od_master_model M (.clk(clk), .od_req(od_req), .od_write(od_write), .od_index(od_index),
        .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack(od_ack),
        .od_abort(od_abort), .od_rdata(od_rdata));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, input logic exp_ab, output logic [31:0] rd);
        logic ab;
        logic ok;
        M.access(wr, idx, sub, wd, rd, ab, ok);
        if (ok !== 1'b1)
        begin
            fails++;
            $display("FAIL od_ack expected 1 seen 0");
            final_report();
        end
        else
            chk($sformatf("od_abort %h.%h", idx, sub), {31'h0, exp_ab}, {31'h0, ab});
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
        logic [31:0] rd;
        xfer(1'b0, idx, sub, 32'h0, 1'b0, rd);
        chk($sformatf("od_rdata %h.%h", idx, sub), exp, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        logic [31:0] rd;
        rdchk(16'h1000, 8'h00, 32'h00020192);
        xfer(1'b1, 16'h1000, 8'h00, 32'h1, 1'b1, rd);
        rdchk(16'h1000, 8'h00, 32'h00020192);
        xfer(1'b0, 16'h2000, 8'h00, 32'h0, 1'b1, rd);
        rdchk(16'h1001, 8'h00, 32'h0);
        rdchk(16'h1003, 8'h00, 32'h0);
        rdchk(16'h1010, 8'h03, 32'h2);
        rdchk(16'h1018, 8'h00, 32'h4);
        rdchk(16'h1018, 8'h01, VENDOR);
        rdchk(16'h1018, 8'h02, PRODUCT);
        rdchk(16'h1018, 8'h03, 32'h00020005);
        rdchk(16'h1018, 8'h04, 32'h0);
        xfer(1'b1, 16'h1018, 8'h04, 32'h5, 1'b1, rd);
        rdchk(16'h1600, 8'h00, 32'h2);
        rdchk(16'h1600, 8'h01, 32'h60400010);
        rdchk(16'h1600, 8'h02, 32'h60ff0020);
        rdchk(16'h1600, 8'h03, 32'h0);
        rdchk(16'h1a02, 8'h00, 32'h0);
    endtask

    task automatic t_fault();
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            fault_flags <= k ? 8'h41 : 8'hff;
            repeat (2) @(posedge clk);
            #1;
            chk("fault_summary", k ? 32'h01 : 32'hbf, {24'h0, fault_summary});
            rdchk(16'h1001, 8'h00, k ? 32'h01 : 32'hbf);
        end
    endtask

    task automatic t_history();
        logic [31:0] rd;
        for (int k = 1; k <= 9; k++)
        begin
            @(posedge clk);
            alarm_event  <= 1'b1;
            alarm_number <= k[15:0];
            alarm_emcy   <= 16'h8000 | k[15:0];
            @(posedge clk);
            alarm_event  <= 1'b0;
            rdchk(16'h1003, 8'h00, (k < 8) ? k : 8);
        end
        rdchk(16'h1003, 8'h01, 32'h80090009);
        rdchk(16'h1003, 8'h08, 32'h80020002);
        xfer(1'b1, 16'h1003, 8'h01, 32'h0, 1'b1, rd);
    endtask

    task automatic t_store();
        logic [31:0] rd;
        @(posedge clk);
        servo_on <= 1'b1;
        obj[0]   <= 32'h20000000;
        xfer(1'b1, 16'h1010, 8'h03, SIGNATURE, 1'b1, rd);
        chk("homing_method_param", 32'h1, par[3]);
        chk("auto home_offset_param", 32'h10000000, par_auto[0]);
        @(posedge clk);
        servo_on <= 1'b0;
        xfer(1'b1, 16'h1010, 8'h03, 32'h73617665, 1'b1, rd);
        xfer(1'b1, 16'h1010, 8'h03, SIGNATURE, 1'b0, rd);
        chk("store_done", 32'h1, {31'h0, store_done});
        for (int i = 0; i < 7; i++)
            chk($sformatf("param %0d", i), obj[i], par[i]);
        chk("auto home_offset_param", 32'h20000000, par_auto[0]);
    endtask

    task automatic t_mapping();
        logic [31:0] rd;
        logic        ok;
        logic        ab;
        xfer(1'b1, 16'h1600, 8'h00, 32'h0, 1'b1, rd);
        rdchk(16'h1600, 8'h00, 32'h2);
        @(posedge clk);
        net_preop <= 1'b1;
        M.remap(16'h1a03, 32'h60410020, 4'h8, ok, ab);
        chk("remap 1a03", 32'h1, {31'h0, ok & ~ab});
        rdchk(16'h1a03, 8'h00, 32'h8);
        rdchk(16'h1a03, 8'h08, 32'h60410020);
        xfer(1'b1, 16'h1a03, 8'h01, 32'h60400010, 1'b1, rd);
        M.remap(16'h1603, 32'h60410021, 4'h8, ok, ab);
        chk("remap 1603 refused", 32'h1, {31'h0, ok & ab});
        xfer(1'b1, 16'h1603, 8'h00, 32'h9, 1'b1, rd);
        rdchk(16'h1603, 8'h00, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        fails = 0;
        comparisons = 0;
        {sys_rst, servo_on, net_preop, alarm_event} = 4'h8;
        {fault_flags, alarm_number, alarm_emcy} = '0;
        for (int i = 0; i < 7; i++)
            obj[i] = 32'h10000000 + i;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_fault();
        t_history();
        t_store();
        t_mapping();
        final_report();
    end
endmodule

`default_nettype wire
